// ---- hdl/fls_flash_ctrl.sv ----
// Flash controller: read path, write buffer, commands, locks, NVM, boot map
module fls_flash_ctrl
	import fls_pkg::*;
#(
	parameter int unsigned  PAGES       = PAGES_MAX,
	parameter int unsigned  TAKE_CYC    = ERASE_TAKE_CYC,
	parameter logic [31:0]  FLASH_BASE  = 32'h0040_0000,
	parameter logic [31:0]  ROM_BYTES   = 32'h0000_4000,
	parameter logic [31:0]  BOOT_BYTES  = 32'h0040_0000,
	parameter logic [31:0]  CAL_BITS    = 32'h0000_0000,
	// Arbitrary identifier value
	parameter logic [127:0] UID         = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978,
	parameter logic [15:0]  LOCK_INIT   = 16'h0000,
	parameter logic [1:0]   NVM_INIT    = 2'h0
) (
	// Clock and reset
	input  wire logic                        clk_i,
	input  wire logic                        rst_n_i,
	// Register port
	input  wire logic [7:0]                  reg_addr_i,
	input  wire logic [31:0]                 reg_wdata_i,
	input  wire logic                        reg_we_i,
	input  wire logic                        reg_re_i,
	output logic      [31:0]                 reg_rdata_o,
	// Bus master flash read port
	input  wire logic                        fr_req_i,
	input  wire logic [$clog2(PAGES*64)-1:0] fr_addr_i,
	output logic      [31:0]                 fr_data_o,
	output logic                             fr_valid_o,
	// Address map
	input  wire logic [31:0]                 map_addr_i,
	output logic      [1:0]                  map_sel_o,
	output logic                             boot_flash_o,
	// Device pins
	input  wire logic                        erase_pin_i,
	input  wire logic                        test_mode_pin_i,
	input  wire logic                        prog_select_pin_a_i,
	input  wire logic                        prog_select_pin_b_i,
	// Parallel programming port
	input  wire logic                        pp_valid_i,
	input  wire logic [7:0]                  pp_cmd_i,
	input  wire logic [15:0]                 pp_arg_i,
	input  wire logic [31:0]                 pp_wdata_i,
	output logic                             pp_ready_o,
	output logic                             pp_done_o,
	output logic      [31:0]                 pp_data_o,
	output logic                             pp_en_o,
	// Debug access and status
	input  wire logic                        dbg_req_i,
	output logic                             dbg_grant_o,
	output logic                             security_o,
	output logic                             flash_irq_o
);

	localparam int unsigned WORDS = PAGES * PAGE_WORDS;
	localparam int unsigned AW    = $clog2(WORDS);
	localparam int unsigned PW    = $clog2(PAGES);
	localparam int unsigned OW    = $clog2(PAGE_WORDS);
	localparam int unsigned NL    = PAGES / REGION_PAGES;
	localparam int unsigned LW    = (NL > 1) ? $clog2(NL) : 1;
	localparam int unsigned RS    = $clog2(REGION_PAGES);
	localparam int unsigned BW    = $clog2(BUF_WORDS);

	// Lock region holding a page
	function automatic logic [LW-1:0] region_of(input logic [PW-1:0] pg);
		logic [PW-1:0] t;
		t = pg >> RS; // Integer divide by region size
		return t[LW-1:0];
	endfunction : region_of

	// First word of a page
	function automatic logic [AW-1:0] page_word(input logic [PW-1:0] pg);
		return {pg, {OW{1'b0}}};
	endfunction : page_word

	// Layout descriptor words
	function automatic logic [31:0] desc(input logic [2:0] idx);
		case (idx) // Layout readable at run time
			3'h0:    return 32'(PAGE_BYTES);
			3'h1:    return 32'(PAGES);
			3'h2:    return 32'(REGION_PAGES);
			3'h3:    return 32'(NL);
			3'h4:    return 32'(NVM_BITS);
			3'h5:    return 32'(BUF_BYTES);
			default: return 32'h0000_0000;
		endcase
	endfunction : desc

	logic [31:0]         mem [WORDS];     // Flash array, pages back to back
	logic [31:0]         buf_q [BUF_WORDS]; // Page write buffer
	fls_state_t          st_q;            // Sequencer state
	logic [AW-1:0]       ptr_q;           // Word being programmed or erased
	logic [AW-1:0]       last_q;          // Last word of the operation
	logic                pin_q;           // Operation started by the pin
	logic [NL-1:0]       lock_q;          // Lock bits
	logic [NVM_BITS-1:0] nvm_q;           // NVM bits: security and boot select
	logic [CFG_WS_W-1:0] ws_q;            // Read wait states
	logic                narrow_q;        // 64-bit read mode
	logic                cmd_err_q;       // Sticky refused command
	logic                lock_err_q;      // Sticky lock abort
	logic [31:0]         result_q;        // Last command result
	logic                rd_wait_q;       // Read miss in progress
	logic [CFG_WS_W-1:0] ws_cnt_q;        // Wait states left
	logic [AW-1:0]       rd_addr_q;       // Pending read word
	logic [31:0]         line_q [4];      // Read line buffer
	logic [AW-1:0]       tag_q;           // Line base address
	logic                line_ok_q;       // Line buffer valid
	logic                erase_ev;        // Filtered erase pin event

	// Decoded command
	logic                cmd_go;
	logic                cmd_refuse;
	logic                cmd_bad;
	logic [7:0]          code;
	logic [ARG_W-1:0]    arg;
	logic [PW-1:0]       pg;
	logic                locked;
	logic                lock_abort;
	logic                start_prog;
	logic                start_erase;
	logic                seq_last;
	logic                sw_cmd;
	logic                pp_take;
	logic                st_rd;
	logic                lock_err_d;
	logic [AW-1:0]       rd_base;
	logic                rd_hit;
	logic [1:0]          rd_off;

	// Erase pin filter
	fls_erase_filt #(
		.TAKE_CYC    (TAKE_CYC)
	) u_filt (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.erase_pin_i (erase_pin_i),
		.erase_o     (erase_ev)
	);

	assign sw_cmd  = reg_we_i && (reg_addr_i == REG_CMD);
	assign pp_take = pp_valid_i && pp_ready_o; // Handshaked port
	assign st_rd   = reg_re_i && (reg_addr_i == REG_STATUS);
	assign seq_last = (st_q != FLS_IDLE) && (ptr_q == last_q);

	// Pick the command source; software is refused while busy or in pp mode
	always_comb begin
		cmd_go     = 1'b0;
		cmd_refuse = 1'b0;
		code       = 8'h00;
		arg        = '0;
		if (sw_cmd) begin
			if (st_q == FLS_IDLE && !pp_en_o && !erase_ev) begin
				cmd_go = 1'b1;
				code   = reg_wdata_i[7:0];
				arg    = reg_wdata_i[CMD_ARG_LSB +: ARG_W];
			end else begin
				cmd_refuse = 1'b1;
			end
		end else if (pp_take && !erase_ev) begin // Parallel commands
			cmd_go = 1'b1;
			code   = pp_cmd_i;
			arg    = pp_arg_i;
		end
	end

	// Lock check and command legality
	always_comb begin
		pg     = arg[PW-1:0];
		locked = lock_q[region_of(pg)]; // Region lock bit
		lock_abort = 1'b0;
		cmd_bad    = 1'b0;
		if (cmd_go) begin
			case (code)
				CMD_PROG, CMD_ERASE_PAGE: lock_abort = locked;
				CMD_ERASE_ALL:            lock_abort = |lock_q;
				CMD_GET_DESC, CMD_SET_LOCK, CMD_CLR_LOCK: cmd_bad = 1'b0;
				CMD_SET_NVM:  cmd_bad = (arg >= ARG_W'(NVM_BITS));
				// Security bit cannot be cleared by command
				CMD_CLR_NVM:  cmd_bad = (arg != ARG_W'(NVM_BOOT));
				CMD_PP_READ, CMD_PP_BUF_WR: cmd_bad = sw_cmd;
				default:      cmd_bad = 1'b1;
			endcase
		end
		start_prog  = cmd_go && (code == CMD_PROG) && !locked;
		start_erase = cmd_go && !lock_abort &&
			((code == CMD_ERASE_PAGE) || (code == CMD_ERASE_ALL));
		lock_err_d  = lock_abort || (lock_err_q && !st_rd); // Set wins
	end

	// Program and erase sequencer, one word per cycle
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q   <= FLS_IDLE;
			ptr_q  <= '0;
			last_q <= '0;
			pin_q  <= 1'b0;
		end else if (erase_ev) begin // Pin forces a full erase
			st_q   <= FLS_ERASE;
			ptr_q  <= '0;
			last_q <= AW'(WORDS - 1);
			pin_q  <= 1'b1;
		end else begin
			case (st_q)
				FLS_IDLE: begin
					if (start_prog) begin // Half page from the buffer
						st_q   <= FLS_PROG;
						ptr_q  <= page_word(pg) +
							(arg[ARG_HALF_BIT] ? AW'(BUF_WORDS) : AW'(0));
						last_q <= page_word(pg) + AW'(BUF_WORDS - 1) +
							(arg[ARG_HALF_BIT] ? AW'(BUF_WORDS) : AW'(0));
					end else if (start_erase) begin
						st_q <= FLS_ERASE;
						if (code == CMD_ERASE_ALL) begin
							ptr_q  <= '0;
							last_q <= AW'(WORDS - 1);
						end else begin
							ptr_q  <= page_word(pg);
							last_q <= page_word(pg) + AW'(PAGE_WORDS - 1);
						end
					end
				end
				FLS_PROG, FLS_ERASE: begin
					ptr_q <= AW'(ptr_q + 1'b1);
					if (seq_last) begin
						st_q  <= FLS_IDLE;
						pin_q <= 1'b0;
					end
				end
				default: st_q <= FLS_IDLE;
			endcase
		end
	end

	// Flash array; programming can only clear bits
	always_ff @(posedge clk_i) begin
		if (st_q == FLS_PROG) begin
			mem[ptr_q] <= mem[ptr_q] & buf_q[ptr_q[BW-1:0]];
		end else if (st_q == FLS_ERASE) begin
			mem[ptr_q] <= ERASED_WORD; // Erased words read all ones
		end
	end

	// Write buffer, filled a word at a time, reset to ones after use
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || (st_q == FLS_PROG && seq_last)) begin
			for (int i = 0; i < BUF_WORDS; i++) begin
				buf_q[i] <= ERASED_WORD;
			end
		end else if (st_q != FLS_PROG) begin
			if (reg_we_i && reg_addr_i[REG_BUF_BIT]) begin
				buf_q[reg_addr_i[BW+1:2]] <= reg_wdata_i;
			end else if (cmd_go && !sw_cmd && code == CMD_PP_BUF_WR) begin
				buf_q[arg[BW-1:0]] <= pp_wdata_i;
			end
		end
	end

	// Lock bits
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lock_q <= LOCK_INIT[NL-1:0];
		end else if (erase_ev) begin
			lock_q <= '0; // Pin unlocks everything
		end else if (cmd_go && code == CMD_SET_LOCK) begin
			lock_q[region_of(pg)] <= 1'b1;
		end else if (cmd_go && code == CMD_CLR_LOCK) begin
			lock_q[region_of(pg)] <= 1'b0;
		end
	end

	// NVM bits: security only falls after a pin erase completes
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			nvm_q <= NVM_INIT;
		end else if (erase_ev) begin
			nvm_q[NVM_BOOT] <= 1'b0; // Back to ROM boot
		end else if (seq_last && pin_q) begin
			nvm_q[NVM_SECURITY] <= 1'b0; // After full erase only
		end else if (cmd_go && !cmd_bad && code == CMD_SET_NVM) begin
			nvm_q[arg[0]] <= 1'b1;
		end else if (cmd_go && !cmd_bad && code == CMD_CLR_NVM) begin
			nvm_q[NVM_BOOT] <= 1'b0;
		end
	end

	// Configuration register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ws_q     <= CFG_WS_RST;
			narrow_q <= CFG_NARROW_RST;
		end else if (reg_we_i && reg_addr_i == REG_CFG) begin
			ws_q     <= reg_wdata_i[CFG_WS_LSB +: CFG_WS_W];
			narrow_q <= reg_wdata_i[CFG_NARROW_BIT];
		end
	end

	// Sticky status flags, cleared by reading status; a new event wins
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cmd_err_q   <= 1'b0;
			lock_err_q  <= 1'b0;
			flash_irq_o <= 1'b0;
		end else begin
			cmd_err_q   <= cmd_bad || cmd_refuse || (cmd_err_q && !st_rd);
			lock_err_q  <= lock_err_d;
			flash_irq_o <= lock_err_d; // Lock abort interrupt
		end
	end

	// Command result
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			result_q <= 32'h0000_0000;
		end else if (cmd_go && code == CMD_GET_DESC) begin
			result_q <= desc(arg[2:0]);
		end else if (cmd_go && !sw_cmd && code == CMD_PP_READ) begin
			result_q <= mem[arg[AW-1:0]];
		end
	end
	assign pp_data_o = result_q;

	// Line base and hit check for the read port
	always_comb begin
		rd_base = narrow_q ? {fr_addr_i[AW-1:1], 1'b0} :
			{fr_addr_i[AW-1:2], 2'b00}; // Line is 2 or 4 words
		rd_hit  = line_ok_q && (tag_q == rd_base);
		rd_off  = narrow_q ? {1'b0, fr_addr_i[0]} : fr_addr_i[1:0];
	end

	// Read port: hits answer next cycle, misses wait the programmed states
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			fr_valid_o <= 1'b0;
			fr_data_o  <= 32'h0000_0000;
			rd_wait_q  <= 1'b0;
			ws_cnt_q   <= '0;
			rd_addr_q  <= '0;
			tag_q      <= '0;
			line_ok_q  <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				line_q[i] <= 32'h0000_0000;
			end
		end else begin
			fr_valid_o <= 1'b0;
			if (!rd_wait_q && fr_req_i) begin
				if (rd_hit) begin
					fr_data_o  <= line_q[rd_off];
					fr_valid_o <= 1'b1;
				end else begin
					rd_wait_q <= 1'b1;
					ws_cnt_q  <= ws_q;
					rd_addr_q <= fr_addr_i;
					tag_q     <= rd_base;
				end
			end else if (rd_wait_q) begin
				if (ws_cnt_q == '0) begin
					for (int i = 0; i < 4; i++) begin
						line_q[i] <= mem[AW'(tag_q + i)];
					end
					fr_data_o  <= mem[rd_addr_q];
					fr_valid_o <= 1'b1;
					rd_wait_q  <= 1'b0;
					line_ok_q  <= 1'b1;
				end else begin
					ws_cnt_q <= CFG_WS_W'(ws_cnt_q - 1'b1);
				end
			end
			// Stale lines must not survive array changes or a width switch
			if (st_q != FLS_IDLE || (reg_we_i && reg_addr_i == REG_CFG)) begin
				line_ok_q <= 1'b0;
			end
		end
	end

	// Address map, pins, security gating
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			map_sel_o    <= MAP_NONE;
			boot_flash_o <= 1'b0;
			pp_en_o      <= 1'b0;
			pp_ready_o   <= 1'b0;
			pp_done_o    <= 1'b0;
			dbg_grant_o  <= 1'b0;
			security_o   <= 1'b0;
		end else begin
			if (map_addr_i - ROM_BASE < ROM_BYTES) begin
				map_sel_o <= MAP_ROM; // ROM always at its base
			end else if (map_addr_i - BOOT_BASE < BOOT_BYTES) begin
				map_sel_o <= nvm_q[NVM_BOOT] ? MAP_FLASH : MAP_ROM;
			end else if (map_addr_i - FLASH_BASE < 32'(WORDS * 4)) begin
				map_sel_o <= MAP_FLASH;
			end else begin
				map_sel_o <= MAP_NONE;
			end
			boot_flash_o <= nvm_q[NVM_BOOT];
			pp_en_o      <= test_mode_pin_i && !prog_select_pin_a_i &&
				!prog_select_pin_b_i;
			pp_ready_o   <= pp_en_o && !nvm_q[NVM_SECURITY] &&
				(st_q == FLS_IDLE) && !start_prog && !start_erase &&
				!pp_take && !erase_ev;
			pp_done_o    <= pp_take && !erase_ev;
			dbg_grant_o  <= dbg_req_i && !nvm_q[NVM_SECURITY];
			security_o   <= nvm_q[NVM_SECURITY];
		end
	end

	// Register read mux; answer one cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else begin
			reg_rdata_o <= 32'h0000_0000;
			if (reg_re_i) begin
				case (reg_addr_i)
					REG_CFG: begin
						reg_rdata_o[CFG_WS_LSB +: CFG_WS_W] <= ws_q;
						reg_rdata_o[CFG_NARROW_BIT]         <= narrow_q;
					end
					REG_STATUS: begin
						reg_rdata_o[ST_READY_BIT]   <= (st_q == FLS_IDLE);
						reg_rdata_o[ST_CMDERR_BIT]  <= cmd_err_q;
						reg_rdata_o[ST_LOCKERR_BIT] <= lock_err_q;
					end
					REG_RESULT: reg_rdata_o <= result_q;
					REG_LOCK:   reg_rdata_o <= 32'(lock_q);
					REG_NVM:    reg_rdata_o <= 32'(nvm_q);
					REG_CAL:    reg_rdata_o <= CAL_BITS; // Read-only
					REG_UID0:   reg_rdata_o <= UID[31:0];
					REG_UID1:   reg_rdata_o <= UID[63:32];
					REG_UID2:   reg_rdata_o <= UID[95:64];
					REG_UID3:   reg_rdata_o <= UID[127:96];
					default:    reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

endmodule : fls_flash_ctrl

// ---- shared/fls_pkg.sv ----
// Shared constants and types of the flash lock, security and boot controller
package fls_pkg;

	// Flash organisation
	localparam int unsigned PAGE_BYTES   = 256;
	localparam int unsigned PAGE_WORDS   = 64;
	localparam int unsigned PAGES_MAX    = 1024;
	localparam int unsigned BUF_BYTES    = 128;
	localparam int unsigned BUF_WORDS    = 32;
	localparam int unsigned REGION_PAGES = 64;
	localparam int unsigned NVM_BITS     = 2;
	localparam int unsigned NVM_SECURITY = 0;
	localparam int unsigned NVM_BOOT     = 1;
	localparam int unsigned ARG_W        = 16;
	localparam int unsigned ARG_HALF_BIT = 15;
	localparam logic [31:0] ERASED_WORD  = 32'hffff_ffff;

	// Address map
	localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
	localparam logic [31:0] ROM_BASE  = 32'h0080_0000;
	localparam logic [1:0]  MAP_NONE  = 2'h0;
	localparam logic [1:0]  MAP_ROM   = 2'h1;
	localparam logic [1:0]  MAP_FLASH = 2'h2;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CFG    = 8'h00;
	localparam logic [7:0] REG_CMD    = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RESULT = 8'h0c;
	localparam logic [7:0] REG_LOCK   = 8'h10;
	localparam logic [7:0] REG_NVM    = 8'h14;
	localparam logic [7:0] REG_CAL    = 8'h18;
	localparam logic [7:0] REG_UID0   = 8'h20;
	localparam logic [7:0] REG_UID1   = 8'h24;
	localparam logic [7:0] REG_UID2   = 8'h28;
	localparam logic [7:0] REG_UID3   = 8'h2c;
	localparam int unsigned REG_BUF_BIT = 7;

	// Field positions and reset values
	localparam int unsigned CFG_WS_LSB     = 0;
	localparam int unsigned CFG_WS_W       = 4;
	localparam int unsigned CFG_NARROW_BIT = 8;
	localparam logic [3:0]  CFG_WS_RST     = 4'h0;
	localparam logic        CFG_NARROW_RST = 1'b0;
	localparam int unsigned CMD_ARG_LSB    = 8;
	localparam int unsigned ST_READY_BIT   = 0;
	localparam int unsigned ST_CMDERR_BIT  = 1;
	localparam int unsigned ST_LOCKERR_BIT = 2;

	// Command codes
	localparam logic [7:0] CMD_GET_DESC   = 8'h00;
	localparam logic [7:0] CMD_PROG       = 8'h01;
	localparam logic [7:0] CMD_ERASE_PAGE = 8'h03;
	localparam logic [7:0] CMD_ERASE_ALL  = 8'h05;
	localparam logic [7:0] CMD_SET_LOCK   = 8'h08;
	localparam logic [7:0] CMD_CLR_LOCK   = 8'h09;
	localparam logic [7:0] CMD_SET_NVM    = 8'h0b;
	localparam logic [7:0] CMD_CLR_NVM    = 8'h0c;
	localparam logic [7:0] CMD_PP_READ    = 8'h20;
	localparam logic [7:0] CMD_PP_BUF_WR  = 8'h21;

	// Erase pin timing
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned ERASE_IGNORE_MS = 100;
	localparam int unsigned ERASE_TAKE_MS   = 220;
	localparam int unsigned ERASE_TAKE_CYC  =
		ERASE_TAKE_MS * (CLK_HZ / 1000) + 1;

	// Sequencer states
	typedef enum logic [2:0] {
		FLS_IDLE  = 3'b001,
		FLS_PROG  = 3'b010,
		FLS_ERASE = 3'b100
	} fls_state_t;

endpackage : fls_pkg

// ---- hdl/fls_erase_filt.sv ----
// Erase pin level filter: one pulse once the pin stays high long enough
module fls_erase_filt
	import fls_pkg::*;
#(
	parameter int unsigned TAKE_CYC = ERASE_TAKE_CYC
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pin and event
	input  wire logic erase_pin_i,
	output logic      erase_o
);

	localparam int unsigned CW = $clog2(TAKE_CYC + 1);

	logic [CW-1:0] cnt_q;  // High time so far
	logic          done_q; // Already fired for this high level

	// Count high time; short pulses restart from zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q   <= '0;
			done_q  <= 1'b0;
			erase_o <= 1'b0;
		end else begin
			erase_o <= 1'b0;
			if (!erase_pin_i) begin // Low level drops any partial count
				cnt_q  <= '0;
				done_q <= 1'b0;
			end else if (!done_q) begin
				if (cnt_q == CW'(TAKE_CYC)) begin // Long enough
					erase_o <= 1'b1;
					done_q  <= 1'b1;
				end else begin
					cnt_q <= CW'(cnt_q + 1'b1);
				end
			end
		end
	end

endmodule : fls_erase_filt

// ---- tb/fls_flash_ctrl_asserts.sv ----
// Port checker for the flash lock, security and boot controller
module fls_chk
	import fls_pkg::*;
#(
	parameter int unsigned TAKE_CYC  = ERASE_TAKE_CYC,
	parameter logic [31:0] ROM_BYTES = 32'h0000_4000
) (
	// Clock, reset and pins
	input wire logic clk_i, rst_n_i, erase_pin_i, test_mode_pin_i,
	input wire logic prog_select_pin_a_i, prog_select_pin_b_i,
	// Requests
	input wire logic dbg_req_i, reg_re_i, fr_req_i, pp_valid_i,
	input wire logic [31:0] map_addr_i,
	// Answers
	input wire logic [31:0] reg_rdata_o,
	input wire logic [1:0] map_sel_o,
	input wire logic fr_valid_o, pp_ready_o, pp_done_o, pp_en_o,
	input wire logic dbg_grant_o, security_o, boot_flash_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	int unsigned hi_q; // Consecutive high cycles of the erase pin
	logic seen_q;      // A long enough high level was seen
	// Erase pin level length, so a dropped security bit can be traced back
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			hi_q <= 0;
			seen_q <= 1'b0;
		end else begin
			hi_q <= erase_pin_i ? hi_q + 1 : 0;
			if (hi_q >= TAKE_CYC) seen_q <= 1'b1;
		end
	end
	chk_pp_enable: assert property ($past(rst_n_i) |->
		pp_en_o == ($past(test_mode_pin_i) && !$past(prog_select_pin_a_i)
		&& !$past(prog_select_pin_b_i))) else $error("parallel enable wrong");
	chk_debug_secure: assert property ($past(rst_n_i) |->
		dbg_grant_o == ($past(dbg_req_i) && !security_o))
		else $error("debug grant wrong");
	chk_rom_fixed: assert property (map_addr_i >= ROM_BASE &&
		map_addr_i < ROM_BASE + ROM_BYTES |=> map_sel_o == MAP_ROM)
		else $error("rom window not mapped");
	chk_boot_zero: assert property (map_addr_i == BOOT_BASE |=>
		map_sel_o == (boot_flash_o ? MAP_FLASH : MAP_ROM))
		else $error("boot map wrong");
	chk_rdata_quiet: assert property (!$past(reg_re_i) |->
		reg_rdata_o == 32'h0) else $error("read data outside slot");
	chk_wait_bound: assert property (fr_req_i |-> ##[1:17] fr_valid_o)
		else $error("flash read not answered");
	chk_pp_done: assert property (pp_valid_i && pp_ready_o |=>
		pp_done_o && !pp_ready_o) else $error("parallel take wrong");
	chk_ready_gate: assert property ((!pp_en_o || security_o) [*2]
		|-> !pp_ready_o) else $error("parallel ready while barred");
	chk_secure_hold: assert property ($fell(security_o) |-> seen_q)
		else $error("security cleared without pin erase");
endmodule : fls_chk

// ---- tb/fls_master.sv ----
// Bus master model issuing single flash word reads
module fls_master #(
	parameter int unsigned AW = 14
) (
	input  wire logic          clk_i,
	input  wire logic          fr_valid_o,
	output logic               fr_req_i,
	output logic      [AW-1:0] fr_addr_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		fr_req_i = 1'b0;
		fr_addr_i = '0;
	end
	// One request pulse, then a bounded wait for the answer
	task automatic read(input logic [AW-1:0] a);
		int n;
		fr_req_i <= 1'b1;
		fr_addr_i <= a;
		@(posedge clk_i);
		fr_req_i <= 1'b0;
		fr_addr_i <= ~a; // Stale address must not be relied on
		n = 0;
		while (fr_valid_o !== 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
	endtask : read
endmodule : fls_master

// ---- tb/test_fls_flash_ctrl.sv ----
// Self-checking bench of the flash lock, security and boot controller
module test_fls_flash_ctrl
	import fls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned NP = 256; // Smallest array, short erase
	localparam int unsigned TK = 20;  // Shortened erase pin filter
	// Arbitrary identifier value
	localparam logic [127:0] ID = 128'h1111_2222_3333_4444_5555_6666_7777_8888;
	localparam logic [31:0] CAL = 32'h0000_00c3;
	logic clk_i, rst_n_i, reg_we_i, reg_re_i, fr_req_i, fr_valid_o;
	logic erase_pin_i, test_mode_pin_i, prog_select_pin_a_i;
	logic prog_select_pin_b_i, pp_valid_i, pp_ready_o, pp_done_o, pp_en_o;
	logic dbg_req_i, dbg_grant_o, security_o, flash_irq_o, boot_flash_o;
	logic [7:0] reg_addr_i, pp_cmd_i, pg;
	logic [15:0] pp_arg_i;
	logic [13:0] fr_addr_i;
	logic [1:0] map_sel_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, fr_data_o, map_addr_i, r;
	logic [31:0] pp_wdata_i, pp_data_o, seed, mem[32], rq[$], fq[$], pq[$];
	logic re_d = 1'b0;
	int failures, n_checks, cyc, n;
	int unsigned desc[6] = '{PAGE_BYTES, NP, REGION_PAGES, NP / 64, 2, 128};
	fls_flash_ctrl #(.PAGES(NP), .TAKE_CYC(TK), .CAL_BITS(CAL), .UID(ID))
	u_dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
		.reg_re_i, .reg_rdata_o, .fr_req_i, .fr_addr_i, .fr_data_o,
		.fr_valid_o, .map_addr_i, .map_sel_o, .boot_flash_o, .erase_pin_i,
		.test_mode_pin_i, .prog_select_pin_a_i, .prog_select_pin_b_i,
		.pp_valid_i, .pp_cmd_i, .pp_arg_i, .pp_wdata_i, .pp_ready_o,
		.pp_done_o, .pp_data_o, .pp_en_o, .dbg_req_i, .dbg_grant_o,
		.security_o, .flash_irq_o);
	fls_master u_mst (.clk_i, .fr_valid_o, .fr_req_i, .fr_addr_i);
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic cmp(input logic [31:0] e, g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %0t exp %h got %h", $time, e, g);
		end
	endtask : cmp
	task automatic report_and_stop;
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop
	// Register write and read, with a spare edge so strobes never merge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_we_i <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		@(posedge clk_i);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		rq.push_back(e);
		reg_addr_i <= a;
		reg_re_i <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(posedge clk_i);
	endtask : rd
	task automatic cmd(input logic [7:0] c, input logic [15:0] g, input int w);
		wr(REG_CMD, {8'h00, g, c});
		repeat (w) @(posedge clk_i);
	endtask : cmd
	task automatic fread(input logic [13:0] a, input logic [31:0] e);
		fq.push_back(e);
		u_mst.read(a);
	endtask : fread
	// Result watchers: each answer takes the oldest note
	always @(posedge clk_i) begin
		if (re_d) cmp(rq.pop_front(), reg_rdata_o);
		if (fr_valid_o === 1'b1)
			cmp(fq.size() ? fq.pop_front() : 'x, fr_data_o);
		if (pp_done_o === 1'b1)
			cmp(pq.size() ? pq.pop_front() : 'x, pp_data_o);
		re_d <= reg_re_i;
	end
	// Random system addresses and debug requests
	always @(posedge clk_i) begin
		r = $random(seed);
		map_addr_i <= r[1] ? 32'h0 : ROM_BASE + {18'h0, r[15:2]};
		dbg_req_i <= r[0];
	end
	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 60000) begin
			failures++;
			report_and_stop();
		end
	end
	initial begin
		seed = 32'h824e47df;
		{rst_n_i, reg_we_i, reg_re_i, erase_pin_i, pp_valid_i} = '0;
		{test_mode_pin_i, prog_select_pin_a_i, prog_select_pin_b_i} = '0;
		{reg_addr_i, reg_wdata_i, pp_cmd_i, pp_arg_i, pp_wdata_i} = '0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(REG_CFG, 32'h0);
		rd(REG_STATUS, 32'h1);
		rd(REG_CAL, CAL);
		wr(REG_UID0, 32'h0);
		for (int i = 0; i < 4; i++)
			rd(REG_UID0 + 8'(4 * i), ID[32 * i +: 32]);
		rd(8'h30, 32'h0);
		for (int i = 0; i < 6; i++) begin
			cmd(CMD_GET_DESC, 16'(i), 2);
			rd(REG_RESULT, 32'(desc[i]));
		end
		// Whole array erased, then one random half page programmed
		cmd(CMD_ERASE_ALL, 16'h0, NP * 64 + 8);
		for (int i = 0; i < 32; i++) begin
			mem[i] = $random(seed);
			wr(8'h80 + 8'(4 * i), mem[i]);
		end
		pg = 8'($random(seed));
		cmd(CMD_PROG, {8'h00, pg}, 40);
		for (int i = 0; i < 32; i++) fread({pg, 6'(i)}, mem[i]);
		fread({pg, 6'd40}, ERASED_WORD);
		wr(REG_CFG, 32'h0000_0103);
		rd(REG_CFG, 32'h0000_0103);
		for (int i = 0; i < 8; i++) fread({pg, 6'(i)}, mem[i]);
		// Locked region refuses program and erase
		cmd(CMD_SET_LOCK, {8'h00, pg}, 4);
		rd(REG_LOCK, 32'h1 << pg[7:6]);
		wr(8'h80, 32'h0);
		cmd(CMD_PROG, {8'h00, pg}, 40);
		cmd(CMD_ERASE_PAGE, {8'h00, pg}, 70);
		cmp(32'h1, {31'h0, flash_irq_o});
		rd(REG_STATUS, 32'h5);
		fread({pg, 6'd0}, mem[0]);
		cmd(CMD_CLR_LOCK, {8'h00, pg}, 4);
		rd(REG_LOCK, 32'h0);
		cmd(CMD_ERASE_PAGE, {8'h00, pg}, 70);
		fread({pg, 6'd1}, ERASED_WORD);
		cmd(CMD_SET_LOCK, 16'h0, 4);
		// Boot select and security bits; security cannot be cleared
		cmd(CMD_SET_NVM, 16'h1, 4);
		cmd(CMD_SET_NVM, 16'h0, 4);
		cmd(CMD_CLR_NVM, 16'h0, 4);
		rd(REG_STATUS, 32'h3);
		rd(REG_NVM, 32'h3);
		cmd(CMD_CLR_NVM, 16'h1, 4);
		rd(REG_NVM, 32'h1);
		cmd(CMD_SET_NVM, 16'h1, 4);
		test_mode_pin_i <= 1'b1;
		pp_cmd_i <= CMD_PP_READ;
		pp_arg_i <= {2'h0, pg, 6'h05};
		pp_valid_i <= 1'b1;
		erase_pin_i <= 1'b1;
		prog_select_pin_a_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		erase_pin_i <= 1'b0;
		prog_select_pin_a_i <= 1'b0;
		prog_select_pin_b_i <= 1'b1;
		rd(REG_NVM, 32'h3);
		erase_pin_i <= 1'b1;
		prog_select_pin_b_i <= 1'b0;
		repeat (TK + 4) @(posedge clk_i);
		erase_pin_i <= 1'b0;
		rd(REG_LOCK, 32'h0);
		// Parallel read held pending; taken only once security is gone
		pq.push_back(ERASED_WORD);
		n = 0;
		do @(posedge clk_i); while (pp_ready_o !== 1'b1 && ++n < NP * 70);
		pp_valid_i <= 1'b0;
		rd(REG_NVM, 32'h0);
		repeat (3) @(posedge clk_i);
		test_mode_pin_i <= 1'b0;
		fread({pg, 6'd0}, ERASED_WORD);
		// Let the watchers take the last answers before counting leftovers
		repeat (2) @(posedge clk_i);
		cmp(32'h0, 32'(rq.size() + fq.size() + pq.size()));
		report_and_stop();
	end
endmodule : test_fls_flash_ctrl
bind fls_flash_ctrl fls_chk #(.TAKE_CYC(TAKE_CYC), .ROM_BYTES(ROM_BYTES))
u_chk (.clk_i, .rst_n_i, .erase_pin_i, .test_mode_pin_i,
	.prog_select_pin_a_i, .prog_select_pin_b_i, .dbg_req_i, .reg_re_i,
	.fr_req_i, .pp_valid_i, .map_addr_i, .reg_rdata_o, .map_sel_o,
	.fr_valid_o, .pp_ready_o, .pp_done_o, .pp_en_o, .dbg_grant_o,
	.security_o, .boot_flash_o);
